// file: common/sync_serial_defs.svh
// Register offsets, field positions, reset values and timing counts for the serial block
`ifndef SYNC_SERIAL_DEFS_SVH
`define SYNC_SERIAL_DEFS_SVH

`define SS_OFF_CTRL 16'hFF70
`define SS_OFF_MODE 16'hFF71
`define SS_OFF_DLO 16'hFF72
`define SS_OFF_DHI 16'hFF73
`define SS_OFF_IEN 16'hFFE3
`define SS_OFF_IFLG 16'hFFF3

`define SS_CTRL_PORT_SEL 0
`define SS_CTRL_TRIG 1
`define SS_CTRL_TXOE 2
`define SS_MODE_CLKSEL_LO 0
`define SS_MODE_CLKSEL_HI 1
`define SS_MODE_EDGE 2
`define SS_MODE_ORDER 3
`define SS_IRQ_BIT 0

`define SS_RST_BIT 1'b0
`define SS_RST_CLKSEL 2'h0
`define SS_LAST_BIT 3'h7

`define SS_MAX_SLAVE_CLK_KHZ 1000
`define SS_REF_CLK_KHZ 125000
`define SS_MIN_HALF_CYC ((`SS_REF_CLK_KHZ + 2 * `SS_MAX_SLAVE_CLK_KHZ - 1) / (2 * `SS_MAX_SLAVE_CLK_KHZ))

`endif

// file: common/sync_serial_pkg.sv
// Types shared by the serial shift block
package sync_serial_pkg;
  typedef enum logic [1:0] {
    CLK_EXT = 2'h0,
    CLK_TIMER = 2'h1,
    CLK_OSC_HALF = 2'h2,
    CLK_OSC = 2'h3
  } clk_src_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ARMED = 3'h2,
    ST_RUN = 3'h4
  } shift_state_e;

  typedef struct packed {
    logic port_sel;
    logic tx_oe;
    logic edge_sel;
    logic msb_first;
    clk_src_e clk_src;
  } serial_cfg_s;

  typedef struct packed {
    logic data_in;
    logic data_out;
    logic data_oe;
    logic ready;
  } serial_pins_s;
endpackage : sync_serial_pkg

// file: src/sync_serial_shift_control.sv
// Synchronous serial shift controller with APB register access
//
// Design decision made here: the APB register port.
`include "sync_serial_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module sync_serial_shift_control
  import sync_serial_pkg::*;
#(
  parameter bit CLK_POS_POLARITY = 1'b0,
  parameter bit READY_POS_POLARITY = 1'b0
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic osc_low_tick_in,
  input wire logic timer_underflow_in,
  input wire logic serial_in_pin_in,
  input wire logic sclk_pin_in,
  output logic sclk_pin_out,
  output logic sclk_pin_oe_out,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_out,
  output logic slave_ready_out,
  output logic slave_ready_oe_out,
  output logic port_select_out,
  output logic serial_irq_out
);

  serial_cfg_s cfg_r;
  shift_state_e state_r;
  shift_state_e state_nxt;
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic run_r;
  logic irq_en_r;
  logic irq_flag_r;
  logic ready_r;
  logic sclk_r;
  logic sclk_prev_r;
  logic osc_half_r;
  logic timer_half_r;
  logic serial_out_pin_r;
  logic [31:0] prdata_r;

  // APB decode
  wire logic bus_access = psel_in & penable_in;
  wire logic bus_wr = bus_access & pwrite_in;
  wire logic bus_rd = bus_access & ~pwrite_in;
  wire logic hit_ctrl = (paddr_in == `SS_OFF_CTRL);
  wire logic hit_mode = (paddr_in == `SS_OFF_MODE);
  wire logic hit_dlo = (paddr_in == `SS_OFF_DLO);
  wire logic hit_dhi = (paddr_in == `SS_OFF_DHI);
  wire logic hit_ien = (paddr_in == `SS_OFF_IEN);
  wire logic hit_iflg = (paddr_in == `SS_OFF_IFLG);
  wire logic hit_any = hit_ctrl | hit_mode | hit_dlo | hit_dhi | hit_ien | hit_iflg;
  wire logic data_access = bus_access & (hit_dlo | hit_dhi);
  wire logic trig_wr = bus_wr & hit_ctrl & pwdata_in[`SS_CTRL_TRIG];
  wire logic slave_mode = (cfg_r.clk_src == CLK_EXT);

  // Rate limit
  // Master clock rates: one-cycle enables toggling the internal shift clock
  // The 1 MHz ceiling is kept by the tick sources feeding these enables
  wire logic master_tick = (cfg_r.clk_src == CLK_OSC) ? osc_low_tick_in :
                           (cfg_r.clk_src == CLK_OSC_HALF) ? (osc_low_tick_in & osc_half_r) :
                           (timer_underflow_in & timer_half_r);

  // Active-edge view of the serial clock; idle level is high for negative polarity
  wire logic sclk_now = slave_mode ? sclk_pin_in : sclk_r;
  wire logic rise = sclk_now & ~sclk_prev_r;
  wire logic fall = ~sclk_now & sclk_prev_r;
  wire logic out_edge = CLK_POS_POLARITY ? rise : fall;
  wire logic sample_edge = (CLK_POS_POLARITY ~^ cfg_r.edge_sel) ? rise : fall;
  wire logic shifting = (state_r == ST_RUN);
  wire logic in_bit = serial_in_pin_in;
  wire logic out_bit = cfg_r.msb_first ? shift_r[7] : shift_r[0];
  wire logic [7:0] shift_in_val = cfg_r.msb_first ? {shift_r[6:0], in_bit} :
                                                    {in_bit, shift_r[7:1]};
  wire logic done = shifting & sample_edge & (bit_cnt_r == `SS_LAST_BIT);
  // First active slave clock edge: leaving idle level
  wire logic first_clk = CLK_POS_POLARITY ? rise : fall;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (trig_wr) begin
          state_nxt = ST_RUN;
        end
      end
      ST_ARMED: begin
        state_nxt = ST_IDLE;
      end
      ST_RUN: begin
        if (done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Reset clears control bits; shift data left as is
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
      cfg_r <= '{`SS_RST_BIT, `SS_RST_BIT, `SS_RST_BIT, `SS_RST_BIT, CLK_EXT};
      irq_en_r <= `SS_RST_BIT;
      run_r <= `SS_RST_BIT;
    end else begin
      state_r <= state_nxt;
      // Run status follows the shift state
      run_r <= (state_nxt == ST_RUN);
      if (bus_wr & hit_ctrl) begin
        cfg_r.port_sel <= pwdata_in[`SS_CTRL_PORT_SEL];
        cfg_r.tx_oe <= pwdata_in[`SS_CTRL_TXOE];
      end
      if (bus_wr & hit_mode) begin
        cfg_r.clk_src <= clk_src_e'(pwdata_in[`SS_MODE_CLKSEL_HI:`SS_MODE_CLKSEL_LO]);
        cfg_r.edge_sel <= pwdata_in[`SS_MODE_EDGE];
        cfg_r.msb_first <= pwdata_in[`SS_MODE_ORDER];
      end
      if (bus_wr & hit_ien) begin
        irq_en_r <= pwdata_in[`SS_IRQ_BIT];
      end
    end
  end

  // Interrupt flag: a completion in the clearing cycle wins
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_flag_r <= `SS_RST_BIT;
    end else if (done) begin
      // Set on completion regardless of mask
      irq_flag_r <= 1'b1;
    end else if (bus_wr & hit_iflg & pwdata_in[`SS_IRQ_BIT]) begin
      irq_flag_r <= 1'b0;
    end
  end

  // Shift register and bit counter
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bit_cnt_r <= 3'h0;
      serial_out_pin_r <= 1'b0;
    end else if (data_access) begin
      // Data access initialises the shift logic
      bit_cnt_r <= 3'h0;
      if (pwrite_in & hit_dlo) begin
        shift_r[3:0] <= pwdata_in[3:0];
      end
      if (pwrite_in & hit_dhi) begin
        shift_r[7:4] <= pwdata_in[3:0];
      end
    end else if (trig_wr & ~shifting) begin
      bit_cnt_r <= 3'h0;
      // First bit presented before the first clock edge
      serial_out_pin_r <= out_bit;
    end else if (shifting) begin
      if (sample_edge) begin
        // Received bit assembled into the data register
        shift_r <= shift_in_val;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (out_edge) begin
        // Next bit onto data-out
        // Taken before this edge's shift lands, so it is right for either sample edge
        serial_out_pin_r <= out_bit;
      end
    end
  end

  // Internal clock generation; idles at its inactive level
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sclk_r <= ~CLK_POS_POLARITY;
      sclk_prev_r <= ~CLK_POS_POLARITY;
      osc_half_r <= 1'b0;
      timer_half_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_now;
      if (osc_low_tick_in) begin
        osc_half_r <= ~osc_half_r;
      end
      if (timer_underflow_in) begin
        timer_half_r <= ~timer_half_r;
      end
      if (~shifting | slave_mode | done) begin
        sclk_r <= ~CLK_POS_POLARITY;
      end else if (master_tick) begin
        sclk_r <= ~sclk_r;
      end
    end
  end

  // Slave ready handshake
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ready_r <= 1'b0;
    end else if (trig_wr & slave_mode) begin
      ready_r <= 1'b1;
    end else if ((shifting & first_clk) | (bus_access & hit_dhi)) begin
      // Dropped at first clock or high nibble access
      ready_r <= 1'b0;
    end
  end

  // APB read data, registered in the setup cycle
  wire logic [3:0] rd_nib = hit_ctrl ? {1'b0, cfg_r.tx_oe, run_r, cfg_r.port_sel} :
                            hit_mode ? {cfg_r.msb_first, cfg_r.edge_sel, cfg_r.clk_src} :
                            hit_dlo ? shift_r[3:0] :
                            hit_dhi ? shift_r[7:4] :
                            hit_ien ? {3'h0, irq_en_r} :
                            hit_iflg ? {3'h0, irq_flag_r} : 4'h0;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      prdata_r <= 32'h0;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      prdata_r <= {28'h0, rd_nib};
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = 1'b1;
  assign pslverr_out = bus_access & ~hit_any;
  // Port select hands the pins to the serial function
  assign port_select_out = cfg_r.port_sel;
  assign sclk_pin_out = sclk_r;
  assign sclk_pin_oe_out = cfg_r.port_sel & ~slave_mode;
  assign serial_out_pin_out = serial_out_pin_r;
  assign serial_out_pin_oe_out = cfg_r.port_sel & cfg_r.tx_oe;
  assign slave_ready_out = READY_POS_POLARITY ? ready_r : ~ready_r;
  assign slave_ready_oe_out = cfg_r.port_sel & slave_mode;
  assign serial_irq_out = irq_flag_r & irq_en_r;

endmodule : sync_serial_shift_control
`default_nettype wire

// file: test/sync_serial_partner.sv
// External serial master that clocks the block in slave mode
`timescale 1ns/100ps
`default_nettype none
module sync_serial_partner #(
  parameter int HALF = 64
) (
  input wire logic ref_clk_in,
  input wire logic sdo_in,
  output logic sclk_out,
  output logic sdi_out
);
  // Clock idles high, data-in line pulled high outside frames
  initial begin
    sclk_out = 1'b1;
    sdi_out = 1'b1;
  end
  // Data held over both edges so either sample edge sees it
  task automatic xfer(input logic [7:0] tx, input logic msb, output logic [7:0] rx);
    int i;
    for (i = 0; i < 8; i++) begin
      sdi_out <= msb ? tx[7 - i] : tx[i];
      // Half period of 64 cycles keeps under 1 MHz
      repeat (HALF) @(posedge ref_clk_in);
      sclk_out <= 1'b0;
      repeat (HALF) @(posedge ref_clk_in);
      rx[msb ? 7 - i : i] = sdo_in;
      sclk_out <= 1'b1;
      // Data held past the rising edge so a rising-edge sampler sees this bit
      repeat (HALF) @(posedge ref_clk_in);
    end
    sdi_out <= 1'b1;
  endtask : xfer
endmodule : sync_serial_partner
`default_nettype wire

// file: test/sync_serial_shift_control_chk.sv
// Port checker for the serial shift block
`timescale 1ns/100ps
`default_nettype none
module sync_serial_shift_control_chk #(
  parameter bit READY_POS_POLARITY = 1'b0
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pslverr_out,
  input wire logic sclk_pin_in,
  input wire logic sclk_pin_oe_out,
  input wire logic serial_out_pin_out,
  input wire logic serial_out_pin_oe_out,
  input wire logic slave_ready_out,
  input wire logic slave_ready_oe_out,
  input wire logic port_select_out,
  input wire logic serial_irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire acc = psel_in && penable_in;
  wire wr = acc && pwrite_in;
  wire mapped = paddr_in inside {16'hFF70, 16'hFF71, 16'hFF72, 16'hFF73, 16'hFFE3, 16'hFFF3};
  // Output may only move near a clock edge or a bus access
  sequence quiet_s;
    (!psel_in && $stable(sclk_pin_in)) [*6];
  endsequence
  rst_clear_a: assert property ($past(sys_rst_in) |->
    !serial_irq_out && !port_select_out && slave_ready_out == !READY_POS_POLARITY)
    else $error("outputs not idle after reset");
  pins_gated_a: assert property (!port_select_out |->
    !(serial_out_pin_oe_out || sclk_pin_oe_out || slave_ready_oe_out))
    else $error("pin driven while port not selected");
  mode_excl_a: assert property (!(sclk_pin_oe_out && slave_ready_oe_out))
    else $error("clock and ready both driven");
  flag_clear_a: assert property (wr && pwdata_in[0] && paddr_in == 16'hFFF3 |=>
    !serial_irq_out)
    else $error("flag not cleared by write");
  mask_off_a: assert property (wr && !pwdata_in[0] && paddr_in == 16'hFFE3 |=>
    !serial_irq_out)
    else $error("masked request still raised");
  ready_drop_a: assert property (acc && paddr_in == 16'hFF73 |->
    ##[1:2] slave_ready_out == !READY_POS_POLARITY)
    else $error("ready kept after high nibble access");
  out_quiet_a: assert property (quiet_s |=> $stable(serial_out_pin_out))
    else $error("data out moved without clock edge");
  unmapped_err_a: assert property (acc |-> pslverr_out == !mapped)
    else $error("wrong error response");
endmodule : sync_serial_shift_control_chk
bind sync_serial_shift_control sync_serial_shift_control_chk #(
  .READY_POS_POLARITY(READY_POS_POLARITY)
) chk_i (.*);
`default_nettype wire

// file: test/sync_serial_shift_control_tb.sv
// Self-checking bench for the serial shift block
`timescale 1ns/100ps
`default_nettype none
module sync_serial_shift_control_tb;
  import sync_serial_pkg::*;
  logic ref_clk_in, sys_rst_in, psel, penable, pwrite, osc, tmr, sclk, sdi;
  logic sdo, sdo_oe, sclk_o, sclk_oe, rdy, rdy_oe, psel_o, irq, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  int seed = 13597;
  int checks_done = 0;
  int miscompares = 0;
  int cycles = 0;
  int exp_q[$];
  sync_serial_shift_control sync_serial_shift_control_i (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .osc_low_tick_in(osc), .timer_underflow_in(tmr),
    .serial_in_pin_in(sdi), .sclk_pin_in(sclk), .sclk_pin_out(sclk_o),
    .sclk_pin_oe_out(sclk_oe), .serial_out_pin_out(sdo), .serial_out_pin_oe_out(sdo_oe),
    .slave_ready_out(rdy), .slave_ready_oe_out(rdy_oe), .port_select_out(psel_o),
    .serial_irq_out(irq));
  sync_serial_partner sync_serial_partner_i (.ref_clk_in(ref_clk_in), .sdo_in(sdo),
    .sclk_out(sclk), .sdi_out(sdi));
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  // Hang guard, well above the four transfers
  always @(posedge ref_clk_in) begin
    cycles++;
    {osc, tmr} <= 2'($random(seed));
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [3:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {28'h0, d};
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [15:0] a, input logic [3:0] e);
    logic [31:0] q;
    apb(1'b0, a, 4'h0, q);
    chk(q, {28'h0, e});
  endtask : rc
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    logic [15:0] regs[5] = '{16'hFF70, 16'hFF71, 16'hFFE3, 16'hFFF3, 16'hFF7C};
    logic [7:0] t, r, got;
    int k;
    {psel, penable, pwrite} = 3'h0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    sys_rst_in = 1'b1;
    repeat (8) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    foreach (regs[i]) rc(regs[i], 4'h0);
    wr(16'hFF70, 4'h1);
    for (k = 0; k < 4; k++) begin
      wr(16'hFF71, k[3:0]);
      rc(16'hFF71, k[3:0]);
      chk({31'h0, sclk_oe}, {31'h0, k != 0});
    end
    // Every sample edge and bit order, mask on for the last two
    for (k = 0; k < 4; k++) begin
      t = 8'($random(seed));
      r = 8'($random(seed));
      exp_q.push_back(t);
      wr(16'hFFE3, {3'h0, k[1]});
      wr(16'hFF71, {k[1], k[0], 2'h0});
      wr(16'hFF72, t[3:0]);
      wr(16'hFF73, t[7:4]);
      wr(16'hFF70, 4'h5);
      rc(16'hFF70, 4'h5);
      chk({31'h0, rdy}, 32'h1);
      wr(16'hFF70, 4'h7);
      rc(16'hFF70, 4'h7);
      chk({30'h0, rdy, sdo_oe}, 32'h1);
      sync_serial_partner_i.xfer(r, k[1], got);
      chk({24'h0, got}, 32'(exp_q.pop_front()));
      rc(16'hFF70, 4'h5);
      rc(16'hFFF3, 4'h1);
      chk({31'h0, irq}, {31'h0, k[1]});
      rc(16'hFF72, r[3:0]);
      rc(16'hFF73, r[7:4]);
      wr(16'hFFF3, 4'h0);
      rc(16'hFFF3, 4'h1);
      wr(16'hFFF3, 4'h1);
      rc(16'hFFF3, 4'h0);
    end
    summarize();
  end
endmodule : sync_serial_shift_control_tb
`default_nettype wire
